// ==== shared/rro_pkg.sv ====
// Shared constants, types and decode for the return and rotate executor
package rro_pkg;

    // Widths and sizes
    localparam int PC_W = 21;
    localparam int STACK_DEPTH = 31;
    localparam int ADDR_W = 12;
    localparam int BANK_W = 4;
    localparam int DATA_W = 8;

    // Opcode patterns
    localparam logic [15:0] OP_INT_RETURN = 16'h0010;
    localparam logic [15:0] OP_SUB_RETURN = 16'h0012;
    localparam logic [15:0] RET_S_MASK = 16'hfffe;
    localparam logic [7:0] OP_LIT_RETURN_HI = 8'h0c;
    localparam logic [5:0] OP_ROT_CARRY_HI = 6'h0d;
    localparam logic [5:0] OP_ROT_NOCARRY_HI = 6'h11;

    // Operand field positions
    localparam int S_BIT = 0;
    localparam int A_BIT = 8;
    localparam int D_BIT = 9;
    localparam int MSB = DATA_W - 1;

    // Addressing
    localparam logic [7:0] INDEXED_LIMIT = 8'h5f;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;

    // Reset values
    localparam logic [7:0] ACCUM_RESET = 8'h00;
    localparam logic [3:0] BANK_RESET = 4'h0;
    localparam logic [PC_W-1:0] PC_RESET = 21'h000000;

    typedef enum logic [2:0] {
        K_NONE, K_INT_RETURN, K_SUB_RETURN, K_LIT_RETURN,
        K_ROT_CARRY, K_ROT_NOCARRY
    } rro_kind_t;

    typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} rro_phase_t;

    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_STALL} rro_state_t;

    typedef struct packed {
        logic n;
        logic ov;
        logic z;
        logic dc;
        logic c;
    } rro_flags_t;

    localparam rro_flags_t FLAGS_RESET = 5'h00;

    typedef struct packed {
        logic [7:0] accum;
        rro_flags_t flags;
        logic [3:0] bank;
    } rro_shadow_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic rd;
        logic wr;
    } rro_mem_req_t;

    localparam rro_mem_req_t MEM_REQ_RESET = 22'h000000;

    function automatic rro_kind_t rro_decode(input logic [15:0] op);
        if ((op & RET_S_MASK) == OP_INT_RETURN) return K_INT_RETURN;
        if ((op & RET_S_MASK) == OP_SUB_RETURN) return K_SUB_RETURN;
        if (op[15:8] == OP_LIT_RETURN_HI) return K_LIT_RETURN;
        if (op[15:10] == OP_ROT_CARRY_HI) return K_ROT_CARRY;
        if (op[15:10] == OP_ROT_NOCARRY_HI) return K_ROT_NOCARRY;
        return K_NONE;
    endfunction : rro_decode

endpackage : rro_pkg

// ==== design/rro_ret_stack.sv ====
// Return address stack held in flip-flops
`timescale 1ns/1ns
`default_nettype none

module rro_ret_stack
    import rro_pkg::*;
#(
    parameter int WIDTH = PC_W,
    parameter int DEPTH = STACK_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Push from call logic
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    // Pop from return logic
    input wire logic pop,
    output logic [WIDTH-1:0] top,
    output logic empty
);

    localparam int PW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] entry_reg [DEPTH];
    logic [PW-1:0] depth_reg;
    logic full;
    logic do_push;
    logic do_pop;

    assign empty = (depth_reg == '0);
    assign full = (depth_reg == PW'(DEPTH));
    assign do_pop = pop && !empty;
    // A full stack drops a push rather than wrapping, except one that comes with a pop in the same cycle
    assign do_push = push && (!full || do_pop);
    // Popping exposes the entry pushed before, so nesting unwinds in order
    assign top = empty ? '0 : entry_reg[depth_reg - PW'(1)];

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            depth_reg <= '0;
        end else if (do_push && !do_pop) begin
            depth_reg <= depth_reg + PW'(1);
        end else if (do_pop && !do_push) begin
            depth_reg <= depth_reg - PW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (do_push && do_pop) begin
            entry_reg[depth_reg - PW'(1)] <= push_data;
        end else if (do_push) begin
            entry_reg[depth_reg] <= push_data;
        end
    end

endmodule : rro_ret_stack

`default_nettype wire

// ==== design/rro_core.sv ====
// Executor for the return and rotate-left instructions
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - The interrupt return pops the stack into the PC and takes two instruction cycles, the second idle.
// - The interrupt return sets the high or the low priority enable at the end of its first cycle, with the pop.
// - With s set the interrupt return reloads accumulator, flags and bank select from shadows, otherwise not.
// - The literal return writes its 8-bit literal to the accumulator and pops the PC, in two cycles.
// - No return touches the PC high and upper latches, and the literal return changes no flag.
// - The subroutine return pops the PC in two cycles, changes no interrupt enable and, with s clear, no flag.
// - With s set the subroutine return restores accumulator, flags and bank select from shadows.
// - Rotate left through carry shifts bits up, bit 7 goes to carry and the old carry to bit 0.
// - For rotates d at 0 writes the accumulator and d at 1 writes the file register back.
// - For rotates a at 0 picks the access bank and a at 1 picks the bank from bank select.
// - With a at 0 and the extended set on, a file address up to 95 is offset from the index pointer.
// - Rotate through carry updates carry, negative and zero and runs decode, read, process, write.
// - Rotate without carry wraps bit 7 into bit 0, keeps carry and updates only negative and zero.
module rro_core
    import rro_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Instruction stream
    input wire logic instr_valid,
    input wire logic [15:0] instr,
    output var logic instr_ready_reg,
    // Call side of the return stack
    input wire logic call_push,
    input wire logic [PC_W-1:0] call_addr,
    // Interrupt control
    input wire logic irq_priority_mode,
    input wire logic irq_entry_high,
    input wire logic irq_entry_low,
    output var logic high_priority_irq_enable_reg,
    output var logic low_priority_irq_enable_reg,
    // Shadow copies and addressing context
    input wire rro_shadow_t shadow,
    input wire logic extended_set_enable,
    input wire logic [ADDR_W-1:0] index_pointer,
    // Data memory
    output var rro_mem_req_t mem_req_reg,
    input wire logic [7:0] mem_rdata,
    // Core state
    output var logic [PC_W-1:0] pc_reg,
    output var logic [7:0] accum_reg,
    output var rro_flags_t flags_reg,
    output var logic [BANK_W-1:0] bank_select_reg
);

    ////////////////////////////////////////////////////////////////////////
    // Phase and sequencing

    rro_phase_t phase_reg;
    rro_state_t st_reg;
    rro_kind_t kind_reg;
    logic [15:0] ir_reg;
    logic [7:0] fdata_reg;
    logic [7:0] result_reg;
    logic take;
    logic commit;
    logic is_return;
    logic ret_commit;
    logic rot_commit;
    logic [PC_W-1:0] stack_top;
    logic stack_empty;

    assign take = (st_reg == ST_IDLE) && (phase_reg == PH_Q1) && instr_valid;
    assign commit = (st_reg == ST_EXEC) && (phase_reg == PH_Q4);
    assign is_return = (kind_reg == K_INT_RETURN) ||
                       (kind_reg == K_SUB_RETURN) ||
                       (kind_reg == K_LIT_RETURN);
    assign ret_commit = commit && is_return;
    assign rot_commit = commit &&
        ((kind_reg == K_ROT_CARRY) || (kind_reg == K_ROT_NOCARRY));

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            phase_reg <= PH_Q1;
        end else begin
            case (phase_reg)
                PH_Q1: phase_reg <= PH_Q2;
                PH_Q2: phase_reg <= PH_Q3;
                PH_Q3: phase_reg <= PH_Q4;
                default: phase_reg <= PH_Q1;
            endcase
        end
    end

    // Returns hold the core for a second, idle instruction cycle
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st_reg <= ST_IDLE;
        end else begin
            case (st_reg)
                ST_IDLE: if (take) st_reg <= ST_EXEC;
                ST_EXEC: begin
                    if (commit) begin
                        st_reg <= is_return ? ST_STALL : ST_IDLE;
                    end
                end
                ST_STALL: if (phase_reg == PH_Q4) st_reg <= ST_IDLE;
                default: st_reg <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            instr_ready_reg <= 1'b1;
        end else if (phase_reg == PH_Q4) begin
            instr_ready_reg <= !ret_commit &&
                ((st_reg != ST_EXEC) || !is_return);
        end else begin
            instr_ready_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ir_reg <= 16'h0000;
            kind_reg <= K_NONE;
        end else if (take) begin
            ir_reg <= instr;
            kind_reg <= rro_decode(instr);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Rotate datapath: read in Q2, process in Q3, write in Q4

    function automatic logic [ADDR_W-1:0] file_addr(
        input logic [15:0] op, input logic [BANK_W-1:0] bank,
        input logic ext, input logic [ADDR_W-1:0] ptr);
        logic [7:0] f;
        f = op[7:0];
        if (op[A_BIT]) return {bank, f};
        if (ext && f <= INDEXED_LIMIT) begin
            return ADDR_W'(ptr + {4'h0, f});
        end
        if (f <= INDEXED_LIMIT) return {ACCESS_LOW_BANK, f};
        return {ACCESS_HIGH_BANK, f};
    endfunction : file_addr

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            mem_req_reg <= MEM_REQ_RESET;
        end else if (take) begin
            mem_req_reg.rd <= (rro_decode(instr) == K_ROT_CARRY) ||
                              (rro_decode(instr) == K_ROT_NOCARRY);
            mem_req_reg.addr <= file_addr(instr, bank_select_reg,
                extended_set_enable, index_pointer);
        end else if (st_reg == ST_EXEC && phase_reg == PH_Q2) begin
            mem_req_reg.rd <= 1'b0;
        end else if (st_reg == ST_EXEC && phase_reg == PH_Q3) begin
            mem_req_reg.wr <= (kind_reg == K_ROT_CARRY ||
                kind_reg == K_ROT_NOCARRY) && ir_reg[D_BIT];
            mem_req_reg.wdata <= result_reg;
        end else if (commit) begin
            mem_req_reg.wr <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            fdata_reg <= 8'h00;
        end else if (st_reg == ST_EXEC && phase_reg == PH_Q2) begin
            fdata_reg <= mem_rdata;
        end
    end

    // Result is combinational on fdata so it is ready at the Q3 edge
    always_comb begin
        if (kind_reg == K_ROT_CARRY) begin
            result_reg = {fdata_reg[MSB-1:0], flags_reg.c};
        end else begin
            result_reg = {fdata_reg[MSB-1:0], fdata_reg[MSB]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Return stack and program counter

    rro_ret_stack #(
        .WIDTH(PC_W),
        .DEPTH(STACK_DEPTH)
    ) u_stack (
        .clk(clk),
        .reset_n(reset_n),
        .push(call_push),
        .push_data(call_addr),
        .pop(ret_commit),
        .top(stack_top),
        .empty(stack_empty)
    );

    // Only the PC is loaded; the high and upper latches live elsewhere
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pc_reg <= PC_RESET;
        end else if (ret_commit) begin
            pc_reg <= stack_top;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Accumulator, flags and bank select

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            accum_reg <= ACCUM_RESET;
        end else if (ret_commit && kind_reg == K_LIT_RETURN) begin
            accum_reg <= ir_reg[7:0];
        end else if (ret_commit && ir_reg[S_BIT]) begin
            accum_reg <= shadow.accum;
        end else if (rot_commit && !ir_reg[D_BIT]) begin
            accum_reg <= result_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            flags_reg <= FLAGS_RESET;
        end else if (ret_commit && kind_reg != K_LIT_RETURN &&
                     ir_reg[S_BIT]) begin
            flags_reg <= shadow.flags;
        end else if (rot_commit) begin
            flags_reg.n <= result_reg[MSB];
            flags_reg.z <= (result_reg == 8'h00);
            if (kind_reg == K_ROT_CARRY) begin
                flags_reg.c <= fdata_reg[MSB];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            bank_select_reg <= BANK_RESET;
        end else if (ret_commit && kind_reg != K_LIT_RETURN &&
                     ir_reg[S_BIT]) begin
            bank_select_reg <= shadow.bank;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt enables: entry clears, interrupt return sets, set wins

    logic set_high;
    logic set_low;

    always_comb begin
        set_high = 1'b0;
        set_low = 1'b0;
        if (ret_commit && kind_reg == K_INT_RETURN) begin
            // Without priorities the high bit is the global enable
            if (!irq_priority_mode || !high_priority_irq_enable_reg) begin
                set_high = 1'b1;
            end else begin
                set_low = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            high_priority_irq_enable_reg <= 1'b0;
            low_priority_irq_enable_reg <= 1'b0;
        end else begin
            if (set_high) begin
                high_priority_irq_enable_reg <= 1'b1;
            end else if (irq_entry_high) begin
                high_priority_irq_enable_reg <= 1'b0;
            end
            if (set_low) begin
                low_priority_irq_enable_reg <= 1'b1;
            end else if (irq_entry_low) begin
                low_priority_irq_enable_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    AST_RET_STALL: assert property (ret_commit |=>
        (st_reg == ST_STALL)[*4] ##1 (st_reg == ST_IDLE))
        else $error("return did not idle exactly one cycle");
    AST_RET_PC: assert property (ret_commit |=>
        pc_reg == $past(stack_top))
        else $error("pc not loaded from stack top");
    AST_IRQ_SET: assert property (
        ret_commit && kind_reg == K_INT_RETURN && !irq_priority_mode
        |=> high_priority_irq_enable_reg)
        else $error("interrupt return did not set enable");
    AST_SHADOW: assert property (
        ret_commit && kind_reg == K_INT_RETURN && ir_reg[S_BIT]
        |=> accum_reg == $past(shadow.accum) &&
            bank_select_reg == $past(shadow.bank))
        else $error("shadow restore missing");
    AST_NO_SHADOW: assert property (
        ret_commit && kind_reg == K_SUB_RETURN && !ir_reg[S_BIT]
        |=> $stable(accum_reg) && $stable(bank_select_reg))
        else $error("return without s changed state");
    AST_LIT: assert property (ret_commit && kind_reg == K_LIT_RETURN
        |=> accum_reg == $past(ir_reg[7:0]) && $stable(flags_reg))
        else $error("literal return wrong");
    AST_SUB_FLAGS: assert property (
        ret_commit && kind_reg == K_SUB_RETURN && !ir_reg[S_BIT] &&
        !irq_entry_high && !irq_entry_low
        |=> $stable(flags_reg) && $stable(high_priority_irq_enable_reg) &&
            $stable(low_priority_irq_enable_reg))
        else $error("subroutine return altered flags or enables");
    AST_CARRY: assert property (rot_commit && kind_reg == K_ROT_CARRY
        |=> flags_reg.c == $past(fdata_reg[MSB]))
        else $error("carry not taken from bit 7");
    AST_DEST: assert property (take && rro_decode(instr) == K_ROT_CARRY &&
        instr[D_BIT] |=> ##2 mem_req_reg.wr ##1 !mem_req_reg.wr)
        else $error("file write strobe misplaced");
    AST_BANK: assert property (take && instr[A_BIT] &&
        (rro_decode(instr) == K_ROT_CARRY ||
         rro_decode(instr) == K_ROT_NOCARRY)
        |=> mem_req_reg.rd && mem_req_reg.addr[11:8] == $past(bank_select_reg))
        else $error("banked address wrong");
    AST_NOCARRY: assert property (
        rot_commit && kind_reg == K_ROT_NOCARRY
        |=> $stable(flags_reg.c) && flags_reg.z == ($past(fdata_reg) == 8'h00))
        else $error("rotate without carry flags wrong");

    COV_INT_RETURN: cover property (ret_commit && kind_reg == K_INT_RETURN);
    COV_LIT_RETURN: cover property (ret_commit && kind_reg == K_LIT_RETURN);
    COV_ROT_FILE: cover property (rot_commit && ir_reg[D_BIT]);
    COV_ROT_ACCUM: cover property (rot_commit && !ir_reg[D_BIT]);

endmodule : rro_core

`default_nettype wire

// ==== dv/rro_data_mem.sv ====
// Data memory model facing the executor's request port
`timescale 1ns/1ns
`default_nettype none

module rro_data_mem
    import rro_pkg::*;
(
    // Clock
    input wire logic clk,
    // Request from the executor and read answer
    input wire rro_mem_req_t mem_req,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [0:(1<<ADDR_W)-1];
    logic [7:0] last_q;

    ////////////////////////////////////////////////////////////////////////
    // Outside a read the bus shows the inverse of the last byte, so a
    // late sample cannot pass by luck
    assign mem_rdata = mem_req.rd ? mem[mem_req.addr] : ~last_q;

    // Plain always: the bench also preloads this array directly
    always @(posedge clk) begin
        if (mem_req.rd) begin
            last_q <= mem[mem_req.addr];
        end
        if (mem_req.wr) begin
            mem[mem_req.addr] <= mem_req.wdata;
        end
    end

    initial last_q = 8'h00;
endmodule : rro_data_mem

`default_nettype wire

// ==== dv/return_and_rotate_ops_test.sv ====
// Self-checking bench for the return and rotate executor
`timescale 1ns/1ns
`default_nettype none

module return_and_rotate_ops_test;
    import rro_pkg::*;

    logic clk;
    logic reset_n;
    logic instr_valid;
    logic [15:0] instr;
    logic instr_ready_reg;
    logic call_push;
    logic [PC_W-1:0] call_addr;
    logic irq_priority_mode;
    logic irq_entry_high;
    logic irq_entry_low;
    logic high_priority_irq_enable_reg;
    logic low_priority_irq_enable_reg;
    rro_shadow_t shadow;
    logic extended_set_enable;
    logic [ADDR_W-1:0] index_pointer;
    rro_mem_req_t mem_req_reg;
    logic [7:0] mem_rdata;
    logic [PC_W-1:0] pc_reg;
    logic [7:0] accum_reg;
    rro_flags_t flags_reg;
    logic [BANK_W-1:0] bank_select_reg;
    int fail_count;
    int num_checks;
    // Expected core state, kept by the bench alone
    logic [PC_W-1:0] e_pc;
    logic [7:0] e_acc;
    rro_flags_t e_fl;
    logic [3:0] e_bank;
    logic e_hi;
    logic e_lo;
    logic [ADDR_W-1:0] seen_addr;
    int seen_len;

    ////////////////////////////////////////////////////////////////////////
    rro_core dut_u (
        .clk(clk), .reset_n(reset_n),
        .instr_valid(instr_valid), .instr(instr),
        .instr_ready_reg(instr_ready_reg),
        .call_push(call_push), .call_addr(call_addr),
        .irq_priority_mode(irq_priority_mode),
        .irq_entry_high(irq_entry_high), .irq_entry_low(irq_entry_low),
        .high_priority_irq_enable_reg(high_priority_irq_enable_reg),
        .low_priority_irq_enable_reg(low_priority_irq_enable_reg),
        .shadow(shadow), .extended_set_enable(extended_set_enable),
        .index_pointer(index_pointer),
        .mem_req_reg(mem_req_reg), .mem_rdata(mem_rdata),
        .pc_reg(pc_reg), .accum_reg(accum_reg), .flags_reg(flags_reg),
        .bank_select_reg(bank_select_reg)
    );

    rro_data_mem mem_u (.clk(clk), .mem_req(mem_req_reg),
        .mem_rdata(mem_rdata));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        if (fail_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic check_state();
        chk("pc", e_pc, pc_reg);
        chk("accum", e_acc, accum_reg);
        chk("flags", e_fl, flags_reg);
        chk("bank", e_bank, bank_select_reg);
        chk("irq_high", e_hi, high_priority_irq_enable_reg);
        chk("irq_low", e_lo, low_priority_irq_enable_reg);
    endtask : check_state

    // Ready is low in every Q2..Q4 clock, so a low ready proves no take;
    // ready high at a falling edge means the next rising edge takes
    task automatic exec(input logic [15:0] op);
        int n;
        n = 0;
        instr = op;
        instr_valid = 1'b1;
        while (instr_ready_reg !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        instr_valid = 1'b0;
        seen_addr = mem_req_reg.addr;
        seen_len = 1;
        while (instr_ready_reg !== 1'b1 && seen_len < 20) begin
            @(negedge clk);
            seen_len++;
        end
        if (n >= 20 || seen_len >= 20) begin
            fail_count++;
            complete_run();
        end
    endtask : exec

    task automatic push(input logic [PC_W-1:0] a);
        call_push = 1'b1;
        call_addr = a;
        @(negedge clk);
        call_push = 1'b0;
        @(negedge clk);
    endtask : push

    task automatic ret(input logic [15:0] op, input logic [PC_W-1:0] top);
        exec(op);
        e_pc = top;
        chk("ret_len", 8, seen_len);
        check_state();
    endtask : ret

    task automatic rot(input logic carry, input logic d, input logic a,
                       input logic [7:0] f, input logic [7:0] v,
                       input logic [ADDR_W-1:0] ea);
        logic [7:0] r;
        mem_u.mem[ea] = v;
        r = carry ? {v[6:0], e_fl.c} : {v[6:0], v[7]};
        if (carry) begin
            e_fl.c = v[7];
        end
        e_fl.n = r[7];
        e_fl.z = (r == 8'h00);
        if (!d) begin
            e_acc = r;
        end
        exec({carry ? OP_ROT_CARRY_HI : OP_ROT_NOCARRY_HI, d, a, f});
        chk("rot_addr", ea, seen_addr);
        chk("rot_len", 4, seen_len);
        chk("rot_mem", d ? r : v, mem_u.mem[ea]);
        check_state();
    endtask : rot

    ////////////////////////////////////////////////////////////////////////
    initial begin
        fail_count = 0;
        num_checks = 0;
        reset_n = 1'b0;
        instr_valid = 1'b0;
        instr = 16'h0000;
        call_push = 1'b0;
        call_addr = '0;
        irq_priority_mode = 1'b0;
        irq_entry_high = 1'b0;
        irq_entry_low = 1'b0;
        shadow = {8'h3c, 5'h15, 4'h3};
        extended_set_enable = 1'b0;
        index_pointer = 12'h200;
        e_pc = '0;
        e_acc = 8'h00;
        e_fl = 5'h00;
        e_bank = 4'h0;
        e_hi = 1'b0;
        e_lo = 1'b0;
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        // Six nested calls; returns must unwind newest first
        push(21'h000a10);
        push(21'h00c456);
        push(21'h1a2b3c);
        push(21'h000777);
        push(21'h0f0f02);
        push(21'h123456);
        ret(OP_SUB_RETURN, 21'h123456);
        e_acc = 8'h3c;
        e_fl = 5'h15;
        e_bank = 4'h3;
        e_hi = 1'b1;
        ret(OP_INT_RETURN | 16'h0001, 21'h0f0f02);
        irq_priority_mode = 1'b1;
        e_lo = 1'b1;
        ret(OP_INT_RETURN, 21'h000777);
        irq_entry_high = 1'b1;
        irq_entry_low = 1'b1;
        @(negedge clk);
        irq_entry_high = 1'b0;
        irq_entry_low = 1'b0;
        e_hi = 1'b1;
        e_lo = 1'b0;
        ret(OP_INT_RETURN, 21'h1a2b3c);
        shadow = {8'h81, 5'h0a, 4'h5};
        e_acc = 8'h5b;
        ret({OP_LIT_RETURN_HI, 8'h5b}, 21'h00c456);
        e_acc = 8'h81;
        e_fl = 5'h0a;
        e_bank = 4'h5;
        ret(OP_SUB_RETURN | 16'h0001, 21'h000a10);
        // Rotates back to back over both destinations, access low and high, bank select and indexed addressing
        rot(1'b1, 1'b0, 1'b0, 8'h20, 8'he6, 12'h020);
        rot(1'b0, 1'b0, 1'b0, 8'h21, 8'h00, 12'h021);
        rot(1'b1, 1'b1, 1'b0, 8'h80, 8'h80, 12'hf80);
        rot(1'b1, 1'b1, 1'b1, 8'h44, 8'h00, 12'h544);
        extended_set_enable = 1'b1;
        rot(1'b0, 1'b1, 1'b0, 8'h5f, 8'hab, 12'h25f);
        rot(1'b0, 1'b0, 1'b0, 8'h60, 8'h80, 12'hf60);
        rot(1'b1, 1'b0, 1'b1, 8'h10, 8'h00, 12'h510);
        complete_run();
    end
endmodule : return_and_rotate_ops_test

`default_nettype wire
